//--- pkg/sacod_pkg.sv
// Shared constants and carriers of the syntax arithmetic codec.
// Assumes one clock domain and a partner that supplies model entries.
package sacod_pkg;

	// Interval points of the 16-bit coder
	localparam logic [15:0] SACOD_QUARTER_POINT = 16'h4000;
	localparam logic [15:0] SACOD_HALF_POINT = 16'h8000;
	localparam logic [15:0] SACOD_THREE_QUARTER_POINT = 16'hC000;
	localparam logic [15:0] SACOD_TOP = 16'hFFFF;

	// Reset values of the coder state
	localparam logic [15:0] SACOD_LOW_RESET = 16'h0000;
	localparam logic [15:0] SACOD_PENDING_RESET = 16'h0000;
	localparam logic [15:0] SACOD_CODE_RESET = 16'h0000;

	// Bits shifted in by decoder initialisation
	localparam logic [4:0] SACOD_INIT_BITS = 5'h10;

	// Zero run after which the guard stuffs or deletes a one
	localparam int SACOD_RUN_ZEROS = 14;

	// Guard buffer size and arithmetic width
	localparam int SACOD_FIFO_DEPTH = 32;
	localparam int SACOD_CALC_W = 34;
	localparam int SACOD_IDX_W = 8;

	// Symbol request to the encoder: model total and the two bracketing entries
	typedef struct packed {
		logic [15:0] total;
		logic [15:0] cumHi;
		logic [15:0] cumLo;
	} sacod_enc_req_type;

	// Decoded symbol answer
	typedef struct packed {
		logic [SACOD_IDX_W-1:0] symbol;
	} sacod_dec_ans_type;

endpackage

//--- hdl/sacod_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
// Assumes a single clock; full and empty come from an occupancy count.
`timescale 1ns/1ns
module sacod_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// Honest full and empty
	assign inReady = count != (AW+1)'(DEPTH);
	assign outValid = count != '0;
	assign outData = store[rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// Storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			store[wrPtr] <= inData;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- hdl/sacod_guard.sv
// Start-code guard on a one-bit stream: stuffs or deletes a one after a zero run.
// Assumes a single clock; STUFF selects the transmit or the receive direction.
`timescale 1ns/1ns
module sacod_guard
	import sacod_pkg::*;
#(
	parameter bit STUFF = 1'b1,
	parameter int RUN = SACOD_RUN_ZEROS
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic inValid,
	input wire logic inBit,
	input wire logic inExempt,
	output logic inReady,
	output logic outValid,
	output logic outBit,
	input wire logic outReady,
	output logic startCode
);
	logic [4:0] zeroRun;
	logic hunting;
	logic atRun;
	logic take;

	assign atRun = zeroRun == 5'(RUN);

	// Stuff a one at the run, drop the first one after it, else pass through
	always_comb begin
		if (STUFF && atRun) begin
			outValid = 1'b1;
			outBit = 1'b1;
			inReady = 1'b0;
		end else if (!STUFF && atRun && inBit) begin
			outValid = 1'b0;
			outBit = 1'b1;
			inReady = 1'b1;
		end else begin
			outValid = inValid;
			outBit = inBit;
			inReady = outReady;
		end
	end

	assign take = inValid && inReady;

	// Zero run counter; start-code bits and hunting do not count
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			zeroRun <= '0;
			hunting <= 1'b0;
			startCode <= 1'b0;
		end else begin
			startCode <= 1'b0;
			if (STUFF && atRun && outReady) begin
				zeroRun <= '0;
			end else if (take) begin
				if (inBit) begin
					zeroRun <= '0;
					hunting <= 1'b0;
				end else if (!STUFF && atRun) begin
					zeroRun <= '0;
					hunting <= 1'b1;
					startCode <= 1'b1;
				end else if (inExempt || hunting) begin
					zeroRun <= '0;
				end else begin
					zeroRun <= zeroRun + 1'b1;
				end
			end
		end
	end
endmodule

//--- hdl/sacod_codec.sv
// Arithmetic encoder and decoder of syntax symbols with start-code guard buffers.
// Assumes partner logic on core_clk supplies model entries and header bit strings.
`timescale 1ns/1ns

// Notes on behaviour
// - Coder works only in arithmetic coding mode; decoder restart is taken in any mode
// - Encoder bounds start 0, 65535, pending 0
// - Symbol given as index into cumulative model
// - Encoder narrows interval from model entries
// - High half: emit one, pending zeros, subtract
// - Middle: subtract quarter, count pending or code
// - Double bounds and repeat until none applies
// - Encoder bits go into guard buffer
// - Decoder computes cum and searches model upward
// - Decoder narrows interval, returns index minus one
// - Decoder renormalises, shifting new bits into code
// - Decoder bits come from guard buffer
// - Decoder initialisation shifts in sixteen bits
// - Upper layer symbol order stays unchanged
// - Coefficient event symbols follow coefficient count
// - Transmit guard stuffs one after 14 zeros
// - Receive guard deletes that one, flags start
// - Flush encoder before each later header
// - Decoder reinitialises after each header string
module sacod_codec #(
	parameter int FIFO_DEPTH = sacod_pkg::SACOD_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic syntaxArithCodingMode,
	input wire logic encValid,
	input wire sacod_pkg::sacod_enc_req_type encReq,
	output logic encReady,
	input wire logic encFlushValid,
	output logic encFlushReady,
	input wire logic hdrTxValid,
	input wire logic hdrTxBit,
	input wire logic hdrTxExempt,
	output logic hdrTxReady,
	output logic txValid,
	output logic txBit,
	input wire logic txReady,
	input wire logic decValid,
	input wire logic [15:0] decTotal,
	output logic decReady,
	input wire logic decRestartValid,
	output logic decRestartReady,
	output logic [sacod_pkg::SACOD_IDX_W-1:0] modelIdx,
	input wire logic [15:0] modelEntry,
	output logic symValid,
	output sacod_pkg::sacod_dec_ans_type symAns,
	input wire logic rxValid,
	input wire logic rxBit,
	output logic rxReady,
	output logic hdrRxValid,
	output logic hdrRxBit,
	input wire logic hdrRxReady,
	output logic startCodeFound
);
	import sacod_pkg::*;

	localparam int CW = SACOD_CALC_W;

	typedef enum logic [1:0] {
		E_IDLE = 2'b00,
		E_RENORM = 2'b01,
		E_BIT = 2'b10,
		E_OPP = 2'b11
	} sacod_enc_state_type;

	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_INIT = 3'b001,
		D_SEARCH = 3'b010,
		D_RENORM = 3'b011,
		D_SHIFT = 3'b100
	} sacod_dec_state_type;

	function automatic logic [31:0] narrow(input logic [15:0] lo, input logic [15:0] hi,
		input logic [15:0] total, input logic [15:0] cHi, input logic [15:0] cLo);
		logic [16:0] len;
		logic [CW-1:0] qHi;
		logic [CW-1:0] qLo;
		len = {1'b0, hi} - {1'b0, lo} + 17'h00001;
		qHi = (CW'(len) * CW'(cHi)) / CW'(total);
		qLo = (CW'(len) * CW'(cLo)) / CW'(total);
		narrow = {16'(CW'(lo) + qHi - CW'(1)), 16'(CW'(lo) + qLo)};
	endfunction

	sacod_enc_state_type eState;
	logic [15:0] eLow;
	logic [15:0] eHigh;
	logic [15:0] pending;
	logic firstBit;
	logic flushing;
	logic [31:0] eNarrow;
	logic encBitValid;
	logic encBit;
	logic stuffInValid;
	logic stuffInBit;
	logic stuffInExempt;
	logic stuffInReady;
	logic stuffOutValid;
	logic stuffOutBit;
	logic stuffOutReady;
	logic [15:0] next_eLow;
	logic [15:0] next_eHigh;
	logic next_flushing;
	sacod_enc_state_type next_eState;

	// requests held off outside arithmetic mode
	assign encReady = eState == E_IDLE && syntaxArithCodingMode && !hdrTxValid;
	assign encFlushReady = encReady;
	assign hdrTxReady = eState == E_IDLE && stuffInReady;

	// model entries bracket the symbol index
	// each event symbol brings its model
	assign eNarrow = narrow(eLow, eHigh, encReq.total, encReq.cumHi, encReq.cumLo);

	// coder bits first, header bits only while idle
	assign encBitValid = eState == E_BIT || eState == E_OPP;
	assign encBit = (eState == E_BIT) ? firstBit : ~firstBit;
	assign stuffInValid = encBitValid || (eState == E_IDLE && hdrTxValid);
	assign stuffInBit = encBitValid ? encBit : hdrTxBit;
	assign stuffInExempt = !encBitValid && hdrTxExempt;

	// doubling after a bit case; a flush reloads instead
	always_comb begin
		if (flushing) begin
			next_eLow = SACOD_LOW_RESET;
			next_eHigh = SACOD_TOP;
			next_flushing = 1'b0;
			next_eState = E_IDLE;
		end else begin
			next_eLow = {eLow[14:0], 1'b0};
			next_eHigh = {eHigh[14:0], 1'b1};
			next_flushing = 1'b0;
			next_eState = E_RENORM;
		end
	end

	// Encoder state machine
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			eState <= E_IDLE;
			eLow <= SACOD_LOW_RESET;
			eHigh <= SACOD_TOP;
			pending <= SACOD_PENDING_RESET;
			firstBit <= 1'b0;
			flushing <= 1'b0;
		end else begin
			unique case (eState)
				E_IDLE: begin
					if (encFlushValid && encReady) begin
						pending <= pending + 16'h0001;
						firstBit <= eLow >= SACOD_QUARTER_POINT;
						flushing <= 1'b1;
						eState <= E_BIT;
					end else if (encValid && encReady) begin
						eHigh <= eNarrow[31:16];
						eLow <= eNarrow[15:0];
						eState <= E_RENORM;
					end
				end
				E_RENORM: begin
					if (eHigh < SACOD_HALF_POINT) begin
						firstBit <= 1'b0;
						eState <= E_BIT;
					end else if (eLow >= SACOD_HALF_POINT) begin
						firstBit <= 1'b1;
						eLow <= eLow - SACOD_HALF_POINT;
						eHigh <= eHigh - SACOD_HALF_POINT;
						eState <= E_BIT;
					end else if (eLow >= SACOD_QUARTER_POINT && eHigh < SACOD_THREE_QUARTER_POINT) begin
						pending <= pending + 16'h0001;
						eLow <= {eLow[14:0] - SACOD_QUARTER_POINT[14:0], 1'b0};
						eHigh <= {eHigh[14:0] - SACOD_QUARTER_POINT[14:0], 1'b1};
					end else begin
						eState <= E_IDLE;
					end
				end
				E_BIT: begin
					if (stuffInReady) begin
						if (pending == 16'h0000) begin
							eLow <= next_eLow;
							eHigh <= next_eHigh;
							flushing <= next_flushing;
							eState <= next_eState;
						end else begin
							eState <= E_OPP;
						end
					end
				end
				E_OPP: begin
					if (stuffInReady) begin
						pending <= pending - 16'h0001;
						if (pending == 16'h0001) begin
							eLow <= next_eLow;
							eHigh <= next_eHigh;
							flushing <= next_flushing;
							eState <= next_eState;
						end
					end
				end
			endcase
		end
	end

	// transmit guard stuffs after a zero run
	sacod_guard #(.STUFF(1'b1), .RUN(SACOD_RUN_ZEROS)) txGuard (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(stuffInValid),
		.inBit(stuffInBit),
		.inExempt(stuffInExempt),
		.inReady(stuffInReady),
		.outValid(stuffOutValid),
		.outBit(stuffOutBit),
		.outReady(stuffOutReady),
		.startCode()
	);

	sacod_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) txFifo (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(stuffOutValid),
		.inData(stuffOutBit),
		.inReady(stuffOutReady),
		.outValid(txValid),
		.outData(txBit),
		.outReady(txReady)
	);

	sacod_dec_state_type dState;
	logic [15:0] dLow;
	logic [15:0] dHigh;
	logic [15:0] code;
	logic [15:0] cum;
	logic [15:0] dTotal;
	logic [15:0] prevEntry;
	logic [SACOD_IDX_W-1:0] idx;
	logic [4:0] initCnt;
	logic primed;
	logic [31:0] dNarrow;
	logic [16:0] dLen;
	logic [16:0] dOffset;
	logic [15:0] cumCalc;
	logic fifoOutValid;
	logic fifoOutBit;
	logic fifoOutReady;
	logic bitValid;
	logic bitVal;
	logic bitReady;
	logic decBitReady;

	sacod_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) rxFifo (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(rxValid),
		.inData(rxBit),
		.inReady(rxReady),
		.outValid(fifoOutValid),
		.outData(fifoOutBit),
		.outReady(fifoOutReady)
	);

	sacod_guard #(.STUFF(1'b0), .RUN(SACOD_RUN_ZEROS)) rxGuard (
		.core_clk(core_clk),
		.rst(rst),
		.inValid(fifoOutValid),
		.inBit(fifoOutBit),
		.inExempt(1'b0),
		.inReady(fifoOutReady),
		.outValid(bitValid),
		.outBit(bitVal),
		.outReady(bitReady),
		.startCode(startCodeFound)
	);

	// coder pulls bits, header reader only while idle
	assign decBitReady = dState == D_INIT || dState == D_SHIFT;
	assign hdrRxValid = dState == D_IDLE && bitValid;
	assign hdrRxBit = bitVal;
	assign bitReady = decBitReady || (dState == D_IDLE && hdrRxReady);

	// decode requests held off outside arithmetic mode; restart taken whenever idle
	assign decReady = dState == D_IDLE && syntaxArithCodingMode && primed && !decRestartValid;
	assign decRestartReady = dState == D_IDLE;
	assign modelIdx = idx;

	assign dLen = {1'b0, dHigh} - {1'b0, dLow} + 17'h00001;
	assign dOffset = {1'b0, code} - {1'b0, dLow} + 17'h00001;
	assign cumCalc = 16'((CW'(dOffset) * CW'(decTotal) - CW'(1)) / CW'(dLen));

	// narrow with entries index-1 and index
	assign dNarrow = narrow(dLow, dHigh, dTotal, prevEntry, modelEntry);

	// Decoder state machine
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dState <= D_IDLE;
			dLow <= SACOD_LOW_RESET;
			dHigh <= SACOD_TOP;
			code <= SACOD_CODE_RESET;
			cum <= '0;
			dTotal <= '0;
			prevEntry <= '0;
			idx <= '0;
			initCnt <= '0;
			primed <= 1'b0;
		end else begin
			unique case (dState)
				D_IDLE: begin
					if (decRestartValid) begin
						code <= SACOD_CODE_RESET;
						dLow <= SACOD_LOW_RESET;
						dHigh <= SACOD_TOP;
						initCnt <= '0;
						primed <= 1'b0;
						dState <= D_INIT;
					end else if (decValid && decReady) begin
						cum <= cumCalc;
						dTotal <= decTotal;
						prevEntry <= decTotal;
						idx <= SACOD_IDX_W'(1);
						dState <= D_SEARCH;
					end
				end
				D_INIT: begin
					if (bitValid) begin
						code <= {code[14:0], bitVal};
						initCnt <= initCnt + 5'h01;
						if (initCnt == SACOD_INIT_BITS - 5'h01) begin
							primed <= 1'b1;
							dState <= D_IDLE;
						end
					end
				end
				D_SEARCH: begin
					if (modelEntry > cum) begin
						prevEntry <= modelEntry;
						idx <= idx + 1'b1;
					end else begin
						dHigh <= dNarrow[31:16];
						dLow <= dNarrow[15:0];
						dState <= D_RENORM;
					end
				end
				D_RENORM: begin
					if (dHigh < SACOD_HALF_POINT) begin
						dLow <= {dLow[14:0], 1'b0};
						dHigh <= {dHigh[14:0], 1'b1};
						dState <= D_SHIFT;
					end else if (dLow >= SACOD_HALF_POINT) begin
						code <= code - SACOD_HALF_POINT;
						dLow <= {dLow[14:0], 1'b0};
						dHigh <= {dHigh[14:0], 1'b1};
						dState <= D_SHIFT;
					end else if (dLow >= SACOD_QUARTER_POINT && dHigh < SACOD_THREE_QUARTER_POINT) begin
						code <= code - SACOD_QUARTER_POINT;
						dLow <= {dLow[14:0] - SACOD_QUARTER_POINT[14:0], 1'b0};
						dHigh <= {dHigh[14:0] - SACOD_QUARTER_POINT[14:0], 1'b1};
						dState <= D_SHIFT;
					end else begin
						dState <= D_IDLE;
					end
				end
				D_SHIFT: begin
					// new bit at the low end
					if (bitValid) begin
						code <= {code[14:0], bitVal};
						dState <= D_RENORM;
					end
				end
				default: begin
					dState <= D_IDLE;
				end
			endcase
		end
	end

	// answer is index minus one after renormalisation
	// answer only once all shifts are done
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			symValid <= 1'b0;
			symAns <= '0;
		end else begin
			symValid <= 1'b0;
			if (dState == D_RENORM && !(dHigh < SACOD_HALF_POINT) && !(dLow >= SACOD_HALF_POINT)
				&& !(dLow >= SACOD_QUARTER_POINT && dHigh < SACOD_THREE_QUARTER_POINT)) begin
				symValid <= 1'b1;
				symAns.symbol <= idx - 1'b1;
			end
		end
	end
endmodule

//--- verif/sacod_codec_props.sv
// Checker of the codec's handshakes and answer timing, bound to the top module.
// Assumes one clock domain and the ports of sacod_codec only.
`timescale 1ns/1ns
module sacod_codec_props #(
	parameter int FIFO_DEPTH = 32
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic syntaxArithCodingMode,
	input wire logic encValid,
	input wire logic encReady,
	input wire logic encFlushReady,
	input wire logic hdrTxValid,
	input wire logic decValid,
	input wire logic decReady,
	input wire logic decRestartValid,
	input wire logic decRestartReady,
	input wire logic [sacod_pkg::SACOD_IDX_W-1:0] modelIdx,
	input wire logic symValid,
	input wire sacod_pkg::sacod_dec_ans_type symAns,
	input wire logic hdrRxValid,
	input wire logic startCodeFound
);
	import sacod_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// Mode gating and reset state
	a_enc_mode_gate: assert property (!syntaxArithCodingMode |-> !encReady)
		else $error("encoder ready while coding mode is off");
	a_dec_mode_gate: assert property (!syntaxArithCodingMode |-> !decReady)
		else $error("decoder ready while coding mode is off");
	a_enc_reset_idle: assert property ($fell(rst) |-> encReady == (syntaxArithCodingMode && !hdrTxValid))
		else $error("encoder not idle after reset");
	// One request at a time
	a_enc_busy_after: assert property (encValid && encReady |=> !encReady)
		else $error("encoder ready right after taking a symbol");
	a_hdr_stalls_enc: assert property (hdrTxValid |-> !encReady && !encFlushReady)
		else $error("encoder ready while a header bit waits");
	a_sym_frees_dec: assert property (symValid && syntaxArithCodingMode && !decRestartValid |-> decReady)
		else $error("decoder not ready with its answer");
	// Decoder search and answer
	a_search_starts_one: assert property (decValid && decReady |=> modelIdx == 8'h01)
		else $error("search does not start at index one");
	a_dec_min_latency: assert property (decValid && decReady |=> !symValid [*2])
		else $error("decoded answer too early");
	a_ans_holds: assert property (!symValid |-> $stable(symAns))
		else $error("answer changed without a valid pulse");
	a_hdr_rx_idle: assert property (hdrRxValid |-> decRestartReady)
		else $error("header bit offered while decoder busy");
	a_start_pulse_one: assert property (startCodeFound |=> !startCodeFound)
		else $error("start code flag longer than one cycle");
endmodule

bind sacod_codec sacod_codec_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.core_clk(core_clk),
	.rst(rst), .syntaxArithCodingMode(syntaxArithCodingMode), .encValid(encValid),
	.encReady(encReady), .encFlushReady(encFlushReady), .hdrTxValid(hdrTxValid),
	.decValid(decValid), .decReady(decReady), .decRestartValid(decRestartValid),
	.decRestartReady(decRestartReady), .modelIdx(modelIdx), .symValid(symValid),
	.symAns(symAns), .hdrRxValid(hdrRxValid), .startCodeFound(startCodeFound));

//--- verif/sacod_model_partner.sv
// Syntax-layer model: answers the decoder's model probes with one fixed model.
// Assumes the codec reads modelEntry in the same cycle that modelIdx shows.
`timescale 1ns/1ns
module sacod_model_partner (
	input wire logic [sacod_pkg::SACOD_IDX_W-1:0] modelIdx,
	output logic [15:0] modelEntry
);
	import sacod_pkg::*;
	always_comb begin
		case (modelIdx)
			8'h00: modelEntry = 16'h3FFF; // Total count
			8'h01: modelEntry = 16'h3000;
			8'h02: modelEntry = 16'h2000;
			8'h03: modelEntry = 16'h0800;
			default: modelEntry = 16'h0000;
		endcase
	end
endmodule

//--- verif/syntax_arith_codec_test.sv
// Self-checking bench: encoder output looped into the decoder, then guard tests.
// Assumes sacod_codec, its checker and the model partner are compiled first.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin totalChecks++; if ((got) !== (exp)) begin nFail++; \
	$display("BAD %s exp=%0h got=%0h", nm, exp, got); end end
module syntax_arith_codec_test;
	import sacod_pkg::*;
	localparam int NSYM = 24;
	logic core_clk, rst, mode, encValid, encFlushValid, hdrTxValid, hdrTxBit, hdrTxExempt;
	logic decValid, decRestartValid, hdrRxReady, chkHdr, expBit;
	logic encReady, encFlushReady, hdrTxReady, txValid, txBit, decReady, decRestartReady;
	logic symValid, rxReady, hdrRxValid, hdrRxBit, startCodeFound;
	logic [15:0] decTotal, modelEntry;
	logic [7:0] expSym, modelIdx;
	logic [15:0] tbl [0:4];
	sacod_enc_req_type encReq;
	sacod_dec_ans_type symAns;
	logic [7:0] symQ[$];
	logic hdrQ[$];
	int nFail, totalChecks, nStart;

	sacod_codec uut (.core_clk(core_clk), .rst(rst), .syntaxArithCodingMode(mode),
		.encValid(encValid), .encReq(encReq), .encReady(encReady),
		.encFlushValid(encFlushValid), .encFlushReady(encFlushReady),
		.hdrTxValid(hdrTxValid), .hdrTxBit(hdrTxBit), .hdrTxExempt(hdrTxExempt),
		.hdrTxReady(hdrTxReady), .txValid(txValid), .txBit(txBit), .txReady(rxReady),
		.decValid(decValid), .decTotal(decTotal), .decReady(decReady),
		.decRestartValid(decRestartValid), .decRestartReady(decRestartReady),
		.modelIdx(modelIdx), .modelEntry(modelEntry), .symValid(symValid), .symAns(symAns),
		.rxValid(txValid), .rxBit(txBit), .rxReady(rxReady), .hdrRxValid(hdrRxValid),
		.hdrRxBit(hdrRxBit), .hdrRxReady(hdrRxReady), .startCodeFound(startCodeFound));
	sacod_model_partner partner (.modelIdx(modelIdx), .modelEntry(modelEntry));

	// Free-running clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	task automatic summarize();
		if (nFail == 0 && totalChecks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Waits for a ready seen settled at the falling edge, then takes it
	task automatic waitRdy(input int k);
		int n;
		logic r;
		n = 0;
		r = 1'b0;
		while (r !== 1'b1) begin
			@(negedge core_clk);
			r = (k == 0) ? encReady : (k == 1) ? encFlushReady : (k == 2) ? hdrTxReady :
				(k == 3) ? decReady : decRestartReady;
			n++;
			if (n > 4000) begin
				nFail++;
				summarize();
			end
		end
		@(posedge core_clk);
	endtask

	task automatic encSym(input int i);
		@(posedge core_clk);
		encValid <= 1'b1;
		encReq <= '{tbl[0], tbl[i], tbl[i+1]};
		symQ.push_back(8'(i));
		waitRdy(0);
		encValid <= 1'b0;
	endtask

	task automatic hdrBit(input logic b, input logic ex);
		@(posedge core_clk);
		hdrTxValid <= 1'b1;
		hdrTxBit <= b;
		hdrTxExempt <= ex;
		waitRdy(2);
		hdrTxValid <= 1'b0;
	endtask

	// Answer monitor, sampled where outputs are settled
	always @(negedge core_clk) begin
		if (!rst) begin
			if (symValid === 1'b1) begin
				expSym = symQ.size() ? symQ.pop_front() : 8'hFF;
				`CHK("symbol", expSym, symAns.symbol)
			end
			if (chkHdr && hdrRxValid === 1'b1 && hdrRxReady) begin
				expBit = hdrQ.size() ? hdrQ.pop_front() : 1'bx;
				`CHK("hdrRxBit", expBit, hdrRxBit)
			end
			if (startCodeFound === 1'b1) nStart++;
		end
	end

	// Main sequence
	initial begin
		tbl = '{16'h3FFF, 16'h3000, 16'h2000, 16'h0800, 16'h0000};
		{rst, mode, encValid, encFlushValid, hdrTxValid, hdrTxBit, hdrTxExempt} = 7'h40;
		{decValid, decRestartValid, hdrRxReady, chkHdr} = 4'h0;
		encReq = '0;
		decTotal = 16'h0000;
		nFail = 0;
		totalChecks = 0;
		nStart = 0;
		void'($urandom(71913));
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK("encReady", 1'b0, encReady)
		`CHK("decReady", 1'b0, decReady)
		@(posedge core_clk);
		mode <= 1'b1;
		@(negedge core_clk);
		`CHK("encReady", 1'b1, encReady)
		`CHK("decReady", 1'b0, decReady)
		fork
			begin
				for (int k = 0; k < NSYM; k++) encSym($urandom_range(3, 0));
				@(posedge core_clk);
				encFlushValid <= 1'b1;
				waitRdy(1);
				encFlushValid <= 1'b0;
				repeat (24) hdrBit(1'b1, 1'b0);
			end
			begin
				@(posedge core_clk);
				decRestartValid <= 1'b1;
				waitRdy(4);
				decRestartValid <= 1'b0;
				repeat (NSYM) begin
					@(posedge core_clk);
					decValid <= 1'b1;
					decTotal <= tbl[0];
					waitRdy(3);
					decValid <= 1'b0;
				end
			end
		join
		hdrRxReady <= 1'b1;
		repeat (300) @(posedge core_clk);
		`CHK("symLeft", 0, symQ.size())
		`CHK("startCount", 0, nStart)
		// Fourteen counted zeros, then 1, 0, 1 must come back unchanged
		chkHdr = 1'b1;
		for (int k = 0; k < 17; k++) begin
			hdrQ.push_back(k == 14 || k == 16);
			hdrBit(k == 14 || k == 16, 1'b0);
		end
		repeat (100) @(posedge core_clk);
		chkHdr = 1'b0;
		`CHK("hdrLeft", 0, hdrQ.size())
		// Exempt zero run, as a start code is sent
		for (int k = 0; k < 18; k++) hdrBit(k == 17, k < 17);
		repeat (100) @(posedge core_clk);
		`CHK("startCount", 1, nStart)
		summarize();
	end
endmodule
